// [hw/dpe_pkg.sv]
`default_nettype none
package dpe_pkg;
   localparam int PERM_W    = 128;
   localparam int PART_W    = 32;
   localparam int PART_N    = 8;
   localparam int ACC_W     = 4;
   localparam logic [4:0] REQ_BYTES = 5'h10;
   localparam logic [3:0] CNT_MAX   = 4'hF;
   localparam logic [1:0] ROLE_NEUTRAL = 2'h0;
   localparam logic [1:0] ROLE_LEAF    = 2'h1;
   localparam logic [1:0] ROLE_SIGNER  = 2'h2;
   localparam int CN_LC     = 0;
   localparam int CN_CLASS  = 1;
   localparam int CN_UNIQ   = 2;
   localparam int CN_CUSTOM = 3;
   localparam logic [7:0] LC_OPEN_MAJOR = 8'h10;
   localparam int SPE_PERM_BIT = 0;
   localparam logic [ACC_W-1:0] ACC_LOCKED = 4'h0;
   localparam logic [ACC_W-1:0] ACC_OPEN   = 4'hF;
   localparam logic [2:0] FAIL_NONE     = 3'h0;
   localparam logic [2:0] FAIL_SCOPE    = 3'h1;
   localparam logic [2:0] FAIL_CONFLICT = 3'h2;
   localparam logic [2:0] FAIL_SIGN     = 3'h3;
   localparam logic [2:0] FAIL_LENGTH   = 3'h4;
   localparam logic [2:0] FAIL_PARTS    = 3'h5;
   localparam logic [2:0] FAIL_EMPTY    = 3'h6;

   typedef enum logic [1:0] {S_IDLE, S_CHAIN, S_PART} dpe_state_t;

   function automatic logic [4:0] dpe_word_round_up(input logic [4:0] n);
      logic [5:0] s;
      s = {1'b0, n} + 6'h03;
      return {s[4:2], 2'b00};
   endfunction

   // access mapping
   // Each access signal is the OR of one 32-bit slice, so a single granted bit opens it.
   function automatic logic [ACC_W-1:0] dpe_access_map(input logic [PERM_W-1:0] eff);
      logic [ACC_W-1:0] a;
      a = '0;
      for (int k = 0; k < ACC_W; k++) begin
         a[k] = |eff[k*32 +: 32];
      end
      return a;
   endfunction
endpackage
`default_nettype wire

// [hw/dpe_scope_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dpe_scope_if;
   logic [15:0]  c_lc;
   logic [15:0]  d_lc;
   logic [31:0]  c_class;
   logic [31:0]  d_class;
   logic [127:0] c_uniq;
   logic [127:0] d_uniq;
   logic [31:0]  c_custom;
   logic [31:0]  d_custom;
   logic [3:0]   nonneutral;
   logic         scope_bad;
   modport main (output c_lc, d_lc, c_class, d_class, c_uniq, d_uniq, c_custom, d_custom,
                 input nonneutral, scope_bad);
   modport check (input c_lc, d_lc, c_class, d_class, c_uniq, d_uniq, c_custom, d_custom,
                  output nonneutral, scope_bad);
endinterface
`default_nettype wire

// [hw/dpe_scope_check.sv]
`timescale 1ns/1ps
`default_nettype none
module dpe_scope_check
   import dpe_pkg::*;
(
   dpe_scope_if.check sc
);
   always_comb begin
      sc.nonneutral[CN_LC]     = |sc.c_lc;
      sc.nonneutral[CN_CLASS]  = |sc.c_class;
      sc.nonneutral[CN_UNIQ]   = |sc.c_uniq;
      sc.nonneutral[CN_CUSTOM] = |sc.c_custom;
      sc.scope_bad = (sc.nonneutral[CN_LC] && sc.c_lc != sc.d_lc)
                  || (sc.nonneutral[CN_CLASS] && sc.c_class != sc.d_class)
                  || (sc.nonneutral[CN_UNIQ] && sc.c_uniq != sc.d_uniq)
                  || (sc.nonneutral[CN_CUSTOM] && sc.c_custom != sc.d_custom);
   end
endmodule
`default_nettype wire

// [hw/dpe_top.sv]
`timescale 1ns/1ps
`default_nettype none
module dpe_top
   import dpe_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic [15:0]       dev_lifecycle,
   input  wire logic [31:0]       dev_class,
   input  wire logic [127:0]      device_unique_constraint,
   input  wire logic [31:0]       dev_custom,
   input  wire logic [PERM_W-1:0] hardware_perm_mask,
   input  wire logic [PERM_W-1:0] fixed_perm_value,
   input  wire logic              eval_start,
   input  wire logic              cert_valid,
   input  wire logic [1:0]        cert_role,
   input  wire logic [15:0]       cert_lifecycle,
   input  wire logic [31:0]       cert_class,
   input  wire logic [127:0]      cert_unique,
   input  wire logic [31:0]       cert_custom,
   input  wire logic [PERM_W-1:0] cert_perm_mask,
   input  wire logic              cert_part_valid,
   input  wire logic [PART_W-1:0] cert_part_id,
   input  wire logic              req_byte_valid,
   input  wire logic [7:0]        req_byte,
   input  wire logic              eval_finish,
   input  wire logic              token_part_valid,
   input  wire logic [PART_W-1:0] token_part_id,
   output logic                   busy,
   output logic                   eval_ok,
   output logic                   eval_fail,
   output logic [2:0]             fail_code,
   output logic [PERM_W-1:0]      eff_perm,
   output logic [ACC_W-1:0]       debug_access,
   output logic                   part_resp_valid,
   output logic                   part_grant
);
   typedef struct packed {
      dpe_state_t                  state;
      logic                        armed;
      logic                        err;
      logic [2:0]                  code;
      logic [3:0]                  ncert;
      logic [PERM_W-1:0]           chain_mask;
      logic [PERM_W-1:0]           req;
      logic [4:0]                  nbytes;
      logic [3:0]                  seen;
      logic [15:0]                 k_lc;
      logic [31:0]                 k_class;
      logic [127:0]                k_uniq;
      logic [31:0]                 k_custom;
      logic [3:0]                  npart;
      logic [PART_N-1:0][PART_W-1:0] parts;
      logic                        ok_p;
      logic                        fail_p;
      logic [PERM_W-1:0]           eff;
      logic [ACC_W-1:0]            access;
      logic                        presp;
      logic                        pgrant;
      logic                        bsy;
   } dpe_main_state_t;

   dpe_main_state_t st;
   dpe_main_state_t next_st;
   dpe_scope_if     sc ();
   logic            conflict;
   logic            sign_bad;
   logic            hit;
   logic            spe_forbid;

   assign sc.c_lc     = cert_lifecycle;
   assign sc.d_lc     = dev_lifecycle;
   assign sc.c_class  = cert_class;
   assign sc.d_class  = dev_class;
   assign sc.c_uniq   = cert_unique;
   assign sc.d_uniq   = device_unique_constraint;
   assign sc.c_custom = cert_custom;
   assign sc.d_custom = dev_custom;

   dpe_scope_check u_check (
      .sc (sc.check)
   );

   always_comb begin
      conflict = (sc.nonneutral[CN_LC] && st.seen[CN_LC] && cert_lifecycle != st.k_lc)
              || (sc.nonneutral[CN_CLASS] && st.seen[CN_CLASS] && cert_class != st.k_class)
              || (sc.nonneutral[CN_UNIQ] && st.seen[CN_UNIQ] && cert_unique != st.k_uniq)
              || (sc.nonneutral[CN_CUSTOM] && st.seen[CN_CUSTOM]
                  && cert_custom != st.k_custom);
      // signing rights
      // Index n signs index n-1, so a certificate after the leaf fails only if its role is ROLE_LEAF.
      sign_bad = (st.ncert != 4'h0) && (cert_role == ROLE_LEAF);
      hit = 1'b0;
      for (int i = 0; i < PART_N; i++) begin
         if (i < int'(st.npart) && st.parts[i] == token_part_id) begin
            hit = 1'b1;
         end
      end
      spe_forbid = !hardware_perm_mask[SPE_PERM_BIT] && !fixed_perm_value[SPE_PERM_BIT];
   end

   always_comb begin
      next_st        = st;
      next_st.ok_p   = 1'b0;
      next_st.fail_p = 1'b0;
      next_st.presp  = 1'b0;
      // lifecycle reset state
      // Only assembly-and-test opens the outputs; every other lifecycle stays locked.
      if (!st.armed) begin
         next_st.armed  = 1'b1;
         next_st.access = (dev_lifecycle[15:8] == LC_OPEN_MAJOR) ? ACC_OPEN : ACC_LOCKED;
      end
      if (eval_start) begin
         next_st.state      = S_CHAIN;
         next_st.err        = 1'b0;
         next_st.code       = FAIL_NONE;
         next_st.ncert      = 4'h0;
         next_st.chain_mask = '1;
         next_st.req        = '0;
         next_st.nbytes     = 5'h00;
         next_st.seen       = 4'h0;
         next_st.npart      = 4'h0;
      end else begin
         case (st.state)
            S_IDLE: begin
               next_st.state = S_IDLE;
            end
            S_CHAIN: begin
               if (cert_valid) begin
                  if (!next_st.err && (sc.scope_bad || conflict || sign_bad)) begin
                     next_st.err  = 1'b1;
                     next_st.code = sc.scope_bad ? FAIL_SCOPE
                                  : (conflict ? FAIL_CONFLICT : FAIL_SIGN);
                  end
                  if (sc.nonneutral[CN_LC]) begin
                     next_st.k_lc = cert_lifecycle;
                  end
                  if (sc.nonneutral[CN_CLASS]) begin
                     next_st.k_class = cert_class;
                  end
                  if (sc.nonneutral[CN_UNIQ]) begin
                     next_st.k_uniq = cert_unique;
                  end
                  if (sc.nonneutral[CN_CUSTOM]) begin
                     next_st.k_custom = cert_custom;
                  end
                  next_st.seen = st.seen | sc.nonneutral;
                  next_st.chain_mask = st.chain_mask & cert_perm_mask;
                  if (st.ncert != CNT_MAX) begin
                     next_st.ncert = st.ncert + 4'h1;
                  end
                  if (cert_part_valid) begin
                     if (st.npart == 4'(PART_N)) begin
                        if (!next_st.err) begin
                           next_st.err  = 1'b1;
                           next_st.code = FAIL_PARTS;
                        end
                     end else begin
                        next_st.parts[st.npart[2:0]] = cert_part_id;
                        next_st.npart = st.npart + 4'h1;
                     end
                  end
               end
               if (req_byte_valid) begin
                  if (st.nbytes < REQ_BYTES) begin
                     next_st.req[{st.nbytes[3:0], 3'b000} +: 8] = req_byte;
                  end
                  if (st.nbytes != 5'h1F) begin
                     next_st.nbytes = st.nbytes + 5'h01;
                  end
               end
               if (eval_finish) begin
                  if (!next_st.err && (next_st.nbytes != dpe_word_round_up(next_st.nbytes)
                                       || next_st.nbytes != REQ_BYTES)) begin
                     next_st.err  = 1'b1;
                     next_st.code = FAIL_LENGTH;
                  end
                  if (!next_st.err && next_st.ncert == 4'h0) begin
                     next_st.err  = 1'b1;
                     next_st.code = FAIL_EMPTY;
                  end
                  if (next_st.err) begin
                     next_st.fail_p = 1'b1;
                     next_st.state  = S_IDLE;
                  end else begin
                     next_st.ok_p   = 1'b1;
                     // fixed inputs, tie both to zero when no provisioning source exists.
                     next_st.eff    = (next_st.req & next_st.chain_mask & hardware_perm_mask)
                                    | (fixed_perm_value & ~hardware_perm_mask);
                     next_st.access = dpe_access_map(next_st.eff);
                     next_st.state  = S_PART;
                  end
               end
            end
            S_PART: begin
               next_st.state = S_PART;
            end
            default: begin
               next_st.state = S_IDLE;
            end
         endcase
      end
      if (token_part_valid) begin
         next_st.presp = 1'b1;
         next_st.pgrant = (st.state == S_PART) && !eval_start
                        && (st.npart == 4'h0 || hit) && !spe_forbid;
      end
      next_st.bsy = (next_st.state == S_CHAIN);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy            = st.bsy;
   assign eval_ok         = st.ok_p;
   assign eval_fail       = st.fail_p;
   assign fail_code       = st.code;
   assign eff_perm        = st.eff;
   assign debug_access    = st.access;
   assign part_resp_valid = st.presp;
   assign part_grant      = st.pgrant;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   property p_eff_hold;
      !$past(sys_rst) && $changed(eff_perm) |-> eval_ok;
   endproperty
   a_eff_hold: assert property (p_eff_hold)
      else $error("effective permissions changed without a successful evaluation");

   property p_eff_fixed;
      eval_ok |-> ((eff_perm & ~$past(hardware_perm_mask))
                  == ($past(fixed_perm_value) & ~$past(hardware_perm_mask)));
   endproperty
   a_eff_fixed: assert property (p_eff_fixed)
      else $error("fixed permission bits not taken from the fixed value");

   property p_eff_chain;
      eval_ok |-> ((eff_perm & hardware_perm_mask & ~st.chain_mask) == '0);
   endproperty
   a_eff_chain: assert property (p_eff_chain)
      else $error("permission granted outside the chain mask");

   property p_scope_fail;
      (st.state == S_CHAIN) && !eval_start && cert_valid && sc.scope_bad |=> st.err;
   endproperty
   a_scope_fail: assert property (p_scope_fail)
      else $error("scope mismatch did not mark the chain as failed");

   property p_conflict_fail;
      (st.state == S_CHAIN) && !eval_start && cert_valid && conflict
         ##1 eval_finish && !eval_start |=> eval_fail && !eval_ok;
   endproperty
   a_conflict_fail: assert property (p_conflict_fail)
      else $error("conflicting constraints did not fail the evaluation");

   property p_sign_fail;
      (st.state == S_CHAIN) && !eval_start && cert_valid && sign_bad |=> st.err;
   endproperty
   a_sign_fail: assert property (p_sign_fail)
      else $error("certificate without signing rights accepted as signer");

   property p_part_listed;
      part_resp_valid && part_grant |-> $past(st.npart == 4'h0 || hit);
   endproperty
   a_part_listed: assert property (p_part_listed)
      else $error("partition granted that the chain does not list");

   property p_part_spe;
      part_resp_valid && part_grant |-> !$past(spe_forbid);
   endproperty
   a_part_spe: assert property (p_part_spe)
      else $error("partition granted while secure environment debug is forbidden");

   property p_reset_state;
      $fell(sys_rst) |-> debug_access == ACC_LOCKED ##1
         debug_access == (($past(dev_lifecycle[15:8]) == LC_OPEN_MAJOR) ? ACC_OPEN : ACC_LOCKED);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("access outputs not in the lifecycle reset state");

   property p_access_map;
      eval_ok |-> debug_access == dpe_access_map(eff_perm);
   endproperty
   a_access_map: assert property (p_access_map)
      else $error("debug access does not follow the effective permissions");

   c_eval_ok: cover property (eval_ok);
   c_eval_fail: cover property (eval_fail && fail_code == FAIL_SCOPE);
   c_part_grant: cover property (part_resp_valid && part_grant && st.npart != 4'h0);
   c_part_deny: cover property (part_resp_valid && !part_grant && st.state == S_PART);
endmodule
`default_nettype wire

// [dv/dpe_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dpe_host_model
   import dpe_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic [15:0]       dev_lifecycle,
   input  wire logic [31:0]       dev_class,
   input  wire logic [127:0]      device_unique_constraint,
   input  wire logic [31:0]       dev_custom,
   input  wire logic              eval_ok,
   input  wire logic              eval_fail,
   input  wire logic              part_resp_valid,
   input  wire logic              part_grant,
   output logic                   eval_start,
   output logic                   cert_valid,
   output logic [1:0]             cert_role,
   output logic [15:0]            cert_lifecycle,
   output logic [31:0]            cert_class,
   output logic [127:0]           cert_unique,
   output logic [31:0]            cert_custom,
   output logic [PERM_W-1:0]      cert_perm_mask,
   output logic                   cert_part_valid,
   output logic [PART_W-1:0]      cert_part_id,
   output logic                   req_byte_valid,
   output logic [7:0]             req_byte,
   output logic                   eval_finish,
   output logic                   token_part_valid,
   output logic [PART_W-1:0]      token_part_id
);
   logic [1:0]        cr_role [2];
   logic [3:0]        cr_sc   [2];
   logic [3:0]        cr_skew [2];
   logic [PERM_W-1:0] cr_mask [2];
   logic              cr_pv   [2];
   logic [PART_W-1:0] cr_pid  [2];

   initial begin
      {eval_start, cert_valid, cert_role, cert_lifecycle, cert_class, cert_unique, cert_custom,
       cert_perm_mask, cert_part_valid, cert_part_id, req_byte_valid, req_byte, eval_finish,
       token_part_valid, token_part_id} = '0;
   end

   // A field with its sc bit clear is sent neutral; a skew bit spoils the device value.
   task automatic run(input int n, input int nb, input logic [PERM_W-1:0] req,
                      output logic ok, output logic fail);
      int last;
      last = (n > nb) ? n : nb;
      @(posedge ref_clk);
      eval_start <= 1'b1;
      for (int c = 0; c <= last; c++) begin
         @(posedge ref_clk);
         eval_start <= 1'b0;
         cert_valid <= c < n;
         if (c < n) begin
            cert_role      <= cr_role[c];
            cert_lifecycle <= cr_sc[c][CN_LC] ? dev_lifecycle ^ 16'(cr_skew[c][CN_LC]) : 16'h0;
            cert_class     <= cr_sc[c][CN_CLASS] ? dev_class ^ 32'(cr_skew[c][CN_CLASS]) : 32'h0;
            cert_unique    <= cr_sc[c][CN_UNIQ] ?
                              device_unique_constraint ^ 128'(cr_skew[c][CN_UNIQ]) : '0;
            cert_custom    <= cr_sc[c][CN_CUSTOM] ?
                              dev_custom ^ 32'(cr_skew[c][CN_CUSTOM]) : 32'h0;
            cert_perm_mask <= cr_mask[c];
            cert_part_valid <= cr_pv[c];
            cert_part_id   <= cr_pid[c];
         end
         req_byte_valid <= c < nb;
         req_byte       <= req[8*(c%16) +: 8];
         eval_finish    <= c == last;
      end
      @(posedge ref_clk);
      eval_finish    <= 1'b0;
      cert_valid     <= 1'b0;
      req_byte_valid <= 1'b0;
      req_byte       <= ~req_byte;
      ok = 1'b0;
      fail = 1'b0;
      for (int w = 0; w < 4 && !(ok || fail); w++) begin
         #1;
         ok = eval_ok;
         fail = eval_fail;
         if (!(ok || fail)) begin
            @(posedge ref_clk);
         end
      end
   endtask

   task automatic ask(input logic [PART_W-1:0] id, output logic grant);
      @(posedge ref_clk);
      token_part_valid <= 1'b1;
      token_part_id    <= id;
      @(posedge ref_clk);
      token_part_valid <= 1'b0;
      token_part_id    <= ~id;
      #1;
      grant = (part_resp_valid === 1'b1) ? part_grant : 1'bx;
   endtask
endmodule
`default_nettype wire

// [dv/debug_permission_evaluator_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module debug_permission_evaluator_bench
   import dpe_pkg::*;
   ;
   logic              ref_clk;
   logic              sys_rst;
   logic [15:0]       dev_lifecycle, cert_lifecycle;
   logic [31:0]       dev_class, dev_custom, cert_class, cert_custom;
   logic [127:0]      device_unique_constraint, cert_unique;
   logic [PERM_W-1:0] hardware_perm_mask, fixed_perm_value, cert_perm_mask, eff_perm, exp_eff;
   logic              eval_start, cert_valid, cert_part_valid, req_byte_valid, eval_finish;
   logic              token_part_valid, busy, eval_ok, eval_fail, part_resp_valid, part_grant;
   logic              ok, fail, g;
   logic [1:0]        cert_role;
   logic [PART_W-1:0] cert_part_id, token_part_id;
   logic [7:0]        req_byte;
   logic [2:0]        fail_code;
   logic [ACC_W-1:0]  debug_access, exp_acc;
   int                bad_count, check_count;
   localparam logic [PERM_W-1:0] MA = {4{32'hFF00_FF0F}};
   localparam logic [PERM_W-1:0] MB = {4{32'h0FF0_F0FF}};
   localparam logic [PERM_W-1:0] RQ = 128'h89AB_CDEF_0000_0000_1357_9BDF_FFFF_FFFF;

   dpe_top uut (
      .ref_clk, .sys_rst, .dev_lifecycle, .dev_class, .device_unique_constraint, .dev_custom,
      .hardware_perm_mask, .fixed_perm_value, .eval_start, .cert_valid, .cert_role,
      .cert_lifecycle, .cert_class, .cert_unique, .cert_custom, .cert_perm_mask,
      .cert_part_valid, .cert_part_id, .req_byte_valid, .req_byte, .eval_finish,
      .token_part_valid, .token_part_id, .busy, .eval_ok, .eval_fail, .fail_code, .eff_perm,
      .debug_access, .part_resp_valid, .part_grant
   );

   dpe_host_model host (
      .ref_clk, .dev_lifecycle, .dev_class, .device_unique_constraint, .dev_custom, .eval_ok,
      .eval_fail, .part_resp_valid, .part_grant, .eval_start, .cert_valid, .cert_role,
      .cert_lifecycle, .cert_class, .cert_unique, .cert_custom, .cert_perm_mask,
      .cert_part_valid, .cert_part_id, .req_byte_valid, .req_byte, .eval_finish,
      .token_part_valid, .token_part_id
   );

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string what, input logic [PERM_W-1:0] seen,
                      input logic [PERM_W-1:0] want);
      check_count++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, want, seen);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic do_reset(input logic [15:0] lc);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      dev_lifecycle <= lc;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      chk("debug_access", PERM_W'(debug_access), PERM_W'(ACC_LOCKED));
      exp_acc = (lc[15:8] == LC_OPEN_MAJOR) ? ACC_OPEN : ACC_LOCKED;
      @(posedge ref_clk);
      #1;
      chk("debug_access", PERM_W'(debug_access), PERM_W'(exp_acc));
      $display("test reset finished");
   endtask

   task automatic cfg(input int i, input logic [1:0] role, input logic [3:0] sc,
                      input logic [3:0] skew, input logic [PERM_W-1:0] m, input logic pv,
                      input logic [PART_W-1:0] pid);
      host.cr_role[i] = role;
      host.cr_sc[i] = sc;
      host.cr_skew[i] = skew;
      host.cr_mask[i] = m;
      host.cr_pv[i] = pv;
      host.cr_pid[i] = pid;
   endtask

   // A code of 7 leaves the failure reason unchecked where two faults coincide.
   task automatic eval(input string name, input int n, input int nb, input logic want,
                       input logic [2:0] code);
      logic [PERM_W-1:0] cm;
      fork
         host.run(n, nb, RQ, ok, fail);
         begin
            repeat (3) @(posedge ref_clk);
            #1;
            chk("busy", PERM_W'(busy), PERM_W'(1'b1));
         end
      join
      chk("busy", PERM_W'(busy), '0);
      chk("eval_ok", PERM_W'(ok), PERM_W'(want));
      chk("eval_fail", PERM_W'(fail), PERM_W'(!want));
      if (want) begin
         cm = '1;
         for (int i = 0; i < n; i++) begin
            cm &= host.cr_mask[i];
         end
         exp_eff = (RQ & cm & hardware_perm_mask) | (fixed_perm_value & ~hardware_perm_mask);
      end
      if (code != 3'h7) begin
         chk("fail_code", PERM_W'(fail_code), PERM_W'(code));
      end
      for (int k = 0; k < ACC_W; k++) begin
         exp_acc[k] = |exp_eff[k*32 +: 32];
      end
      chk("eff_perm", eff_perm, exp_eff);
      chk("debug_access", PERM_W'(debug_access), PERM_W'(exp_acc));
      $display("test %s finished", name);
   endtask

   initial begin
      sys_rst = 1'b1;
      dev_lifecycle = 16'h1000;
      dev_class = 32'hC1A5_5000;
      device_unique_constraint = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
      dev_custom = 32'h0000_C0DE;
      hardware_perm_mask = {32'h0, 64'hFFFF_FFFF_FFFF_FFFF, 32'h0000_FFFF};
      fixed_perm_value = 128'h8000_0000_0000_0000_0000_0000_0001_0000;
      bad_count = 0;
      check_count = 0;
      exp_eff = '0;
      do_reset(16'h1000);
      cfg(0, ROLE_LEAF, 4'hF, 4'h0, MA, 1'b0, 32'h0);
      cfg(1, ROLE_SIGNER, 4'h0, 4'h0, MB, 1'b0, 32'h0);
      eval("chain", 2, 16, 1'b1, FAIL_NONE);
      for (int k = 0; k < 4; k++) begin
         cfg(0, ROLE_LEAF, 4'hF, 4'(1 << k), MA, 1'b0, 32'h0);
         eval("scope", 2, 16, 1'b0, FAIL_SCOPE);
      end
      cfg(0, ROLE_LEAF, 4'h2, 4'h0, MA, 1'b0, 32'h0);
      cfg(1, ROLE_SIGNER, 4'h2, 4'h2, MB, 1'b0, 32'h0);
      eval("conflict", 2, 2, 1'b0, 3'h7);
      cfg(0, ROLE_SIGNER, 4'h0, 4'h0, MA, 1'b0, 32'h0);
      cfg(1, ROLE_LEAF, 4'h0, 4'h0, MB, 1'b0, 32'h0);
      eval("sign", 2, 16, 1'b0, FAIL_SIGN);
      cfg(1, ROLE_SIGNER, 4'h0, 4'h0, MB, 1'b0, 32'h0);
      eval("short", 2, 15, 1'b0, FAIL_LENGTH);
      eval("empty", 0, 16, 1'b0, FAIL_EMPTY);
      cfg(0, ROLE_LEAF, 4'h0, 4'h0, MA, 1'b1, 32'h0000_0A11);
      eval("listed", 2, 16, 1'b1, FAIL_NONE);
      host.ask(32'h0000_0A11, g);
      chk("part_grant", PERM_W'(g), PERM_W'(1'b1));
      host.ask(32'h0000_0B22, g);
      chk("part_grant", PERM_W'(g), PERM_W'(1'b0));
      cfg(0, ROLE_LEAF, 4'h0, 4'h0, MA, 1'b0, 32'h0);
      eval("unlisted", 2, 16, 1'b1, FAIL_NONE);
      host.ask(32'h0000_0B22, g);
      chk("part_grant", PERM_W'(g), PERM_W'(1'b1));
      @(posedge ref_clk);
      hardware_perm_mask <= '0;
      fixed_perm_value <= '0;
      eval("no provisioning", 2, 16, 1'b1, FAIL_NONE);
      host.ask(32'h0000_0B22, g);
      chk("part_grant", PERM_W'(g), PERM_W'(1'b0));
      do_reset(16'h3000);
      wrap_up;
   end

   initial begin
      #50us;
      bad_count++;
      $display("unexpected run length: expected end of tests, seen hang");
      wrap_up;
   end
endmodule
`default_nettype wire
